// File: ccr_regs.sv
// control register slice: output boost, mixers, speaker gain, low power,
// pcm slot and pad options, identification, bias override, level control
// assumes one register access per cycle on a plain address/data port
`timescale 1ns/1ps
import ccr_pkg::*;

module ccr_regs #(
    parameter ccr_pkg::ccr_word_t REV_ID = 9'h0A5, // arbitrary value
    parameter logic [6:0] BUS_ADDR = 7'h2B, // arbitrary value
    parameter ccr_pkg::ccr_word_t EXTRA_ID = 9'h0B3 // arbitrary value
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // register port
    input  wire logic                reg_wr_en,
    input  wire logic                reg_rd_en,
    input  wire ccr_pkg::ccr_addr_t  reg_addr,
    input  wire ccr_pkg::ccr_word_t  reg_wr_data,
    output ccr_pkg::ccr_word_t       reg_rd_data,
    // state from the rest of the codec
    input  wire logic [5:0]          level_gain_readback,
    input  wire logic [1:0]          word_length_field,
    input  wire logic                input_boost_gain_sel,
    // pcm serial port
    input  wire logic                bclk,
    input  wire logic                fs,
    input  wire logic [31:0]         adc_left,
    input  wire logic [31:0]         adc_right,
    output logic                     serial_data_out_pin_o,
    output logic                     serial_data_out_pin_oe,
    output logic                     pad_pull_up,
    output logic                     pad_pull_down,
    // output stage
    output logic [4:0]               boost_stage_gain_db,
    output logic                     mono_out_boost,
    output logic                     speaker_out_boost,
    output logic                     thermal_shutdown_en,
    output logic                     analog_out_resistance,
    // speaker path
    output logic                     aux_to_speaker_mix,
    output logic                     bypass_to_speaker_mix,
    output logic                     dac_to_speaker_mix,
    output logic [5:0]               speaker_gain_code,
    output logic signed [6:0]        speaker_gain_db,
    output logic                     speaker_gain_zero_cross,
    output logic                     speaker_mute,
    // mono path
    output logic                     aux_to_mono_mix,
    output logic                     bypass_to_mono_mix,
    output logic                     dac_to_mono_mix,
    output logic                     mono_drive_vref,
    // low power and trims
    output logic                     low_power_input_boost,
    output logic                     low_power_converter_in,
    output logic                     low_power_speaker_driver,
    output logic                     low_power_converter_out,
    output logic                     mic_bias_mode,
    output logic [3:0]               trim_bits,
    // pcm settings
    output logic [9:0]               pcm_slot_start,
    output logic [5:0]               pcm_word_len,
    output logic                     pcm_slot_mode_en,
    output logic                     pcm_alt_mode,
    // bias override
    output logic                     high_supply_bias_active,
    output logic                     high_supply_bias_high,
    // level control
    output logic                     target_table_select,
    output logic                     level_threshold_source,
    output logic                     gate_threshold_source,
    output logic                     fast_limiter_active
);
    import ccr_pkg::*;

    ccr_word_t regs_q [NRW];
    logic      [NRW-1:0] wr_hit;
    ccr_word_t rd_term [NRW];
    ccr_word_t rd_fix;
    ccr_word_t rd_d;
    logic      fix_hit;
    logic      rw_hit;
    ccr_word_t slot1_w, slot2_w, drv_w, alc1_w;

    logic [4:0]        boost_db_q;
    logic signed [6:0] spk_db_q;
    logic [9:0]        slot_q;
    logic [5:0]        word_length_field_q;
    logic              vref_q;
    logic              hv_act_q;
    logic              hv_high_q;
    logic              lim_act_q;
    logic [31:0]       right_sel;

    // register storage and write decode
    generate
        for (genvar i = 0; i < NRW; i++) begin : g_reg
            assign wr_hit[i] = reg_wr_en && (reg_addr == RW_ADDR[i]);
            assign rd_term[i] = (reg_addr == RW_ADDR[i]) ? regs_q[i] : '0;
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    regs_q[i] <= RW_RST[i];
                end else if (wr_hit[i]) begin
                    regs_q[i] <= reg_wr_data & RW_MASK[i];
                end
            end
        end
    endgenerate

    // fixed contents; writes to these addresses have no target
    assign rd_fix = (reg_addr == A_REV)   ? REV_ID :
                    (reg_addr == A_BUSID) ? {2'b00, BUS_ADDR} :
                    (reg_addr == A_XID)   ? EXTRA_ID :
                    (reg_addr == A_RSVD)  ? RSVD_VAL : '0;
    assign fix_hit = (reg_addr == A_REV) || (reg_addr == A_BUSID)
                  || (reg_addr == A_XID) || (reg_addr == A_RSVD);

    always_comb begin
        rd_d = rd_fix;
        rw_hit = 1'b0;
        for (int i = 0; i < NRW; i++) begin
            rd_d = rd_d | rd_term[i];
            rw_hit = rw_hit | (reg_addr == RW_ADDR[i]);
        end
        if (reg_addr == RW_ADDR[I_ALC1]) begin
            rd_d = rd_d | {3'b000, level_gain_readback};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rd_data <= '0;
        end else if (reg_rd_en) begin
            reg_rd_data <= (rw_hit || fix_hit) ? rd_d : '0;
        end
    end

    // named views of the stored words
    assign slot1_w = regs_q[I_SLOT1];
    assign slot2_w = regs_q[I_SLOT2];
    assign drv_w = regs_q[I_DRV];
    assign alc1_w = regs_q[I_ALC1];

    // output stage
    assign mono_out_boost = regs_q[I_OUT][F_MONO_OUT_BOOST];
    assign speaker_out_boost = regs_q[I_OUT][F_SPEAKER_OUT_BOOST];
    assign thermal_shutdown_en = regs_q[I_OUT][F_THERMAL_SHUTDOWN_EN];
    assign analog_out_resistance = regs_q[I_OUT][F_ANALOG_OUT_RESISTANCE];
    assign boost_stage_gain_db = boost_db_q;

    // speaker path
    assign aux_to_speaker_mix = regs_q[I_SPKMIX][F_MIX_AUX_S];
    assign bypass_to_speaker_mix = regs_q[I_SPKMIX][F_MIX_BYP];
    assign dac_to_speaker_mix = regs_q[I_SPKMIX][F_MIX_DAC];
    assign speaker_gain_code = regs_q[I_SPEAKER_GAIN_CODE][5:0];
    assign speaker_gain_db = spk_db_q;
    assign speaker_gain_zero_cross = regs_q[I_SPEAKER_GAIN_CODE][F_SPK_ZC];
    assign speaker_mute = regs_q[I_SPEAKER_GAIN_CODE][F_SPK_MUTE];

    // mono path
    assign aux_to_mono_mix = regs_q[I_MONOMIX][F_MIX_AUX_M];
    assign bypass_to_mono_mix = regs_q[I_MONOMIX][F_MIX_BYP];
    assign dac_to_mono_mix = regs_q[I_MONOMIX][F_MIX_DAC];
    assign mono_drive_vref = vref_q;

    // low power and trims
    assign low_power_input_boost = regs_q[I_LOWPWR][F_LP_BST];
    assign low_power_converter_in = regs_q[I_LOWPWR][F_LP_ADC];
    assign low_power_speaker_driver = regs_q[I_LOWPWR][F_LP_SPK];
    assign low_power_converter_out = regs_q[I_LOWPWR][F_LP_DAC];
    assign mic_bias_mode = regs_q[I_LOWPWR][F_MICBM];
    assign trim_bits = regs_q[I_LOWPWR][3:0];

    // pcm settings
    assign pcm_slot_start = slot_q;
    assign pcm_word_len = word_length_field_q;
    assign pcm_slot_mode_en = slot2_w[F_SLOT_EN];
    assign pcm_alt_mode = slot2_w[F_ALT];

    // bias override and level control
    assign high_supply_bias_active = hv_act_q;
    assign high_supply_bias_high = hv_high_q;
    assign target_table_select = alc1_w[F_TABLE];
    assign level_threshold_source = alc1_w[F_LVL_SRC];
    assign gate_threshold_source = alc1_w[F_GATE_SRC];
    assign fast_limiter_active = lim_act_q;

    // right slot carries left data when duplicated
    assign right_sel = slot2_w[F_DUP] ? adc_left : adc_right;

    // derived settings
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boost_db_q <= '0;
            spk_db_q <= '0;
            slot_q <= '0;
            word_length_field_q <= WL_TABLE[0];
            vref_q <= 1'b0;
        end else begin
            boost_db_q <= input_boost_gain_sel ? BOOST_DB : '0;
            spk_db_q <= $signed({1'b0, regs_q[I_SPEAKER_GAIN_CODE][5:0]} - SPK_DB_OFS);
            slot_q <= {slot2_w[F_SLOT_MSB], slot1_w};
            word_length_field_q <= slot2_w[F_BYTE] ? WL_BYTE : WL_TABLE[word_length_field];
            vref_q <= regs_q[I_MONOMIX][F_MONO_MUTE] || drv_w[F_OUT_MUTE];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hv_act_q <= 1'b0;
            hv_high_q <= 1'b0;
            lim_act_q <= 1'b1;
        end else begin
            hv_act_q <= drv_w[F_HV_UPD];
            hv_high_q <= drv_w[F_HV_UPD] && drv_w[F_HV_SEL];
            lim_act_q <= !regs_q[I_ALC2][F_LIM_OFF];
        end
    end

    // pcm transmitter and pad
    ccr_pcm_tx u_tx (
        .clk        (clk),
        .rstn       (rstn),
        .bclk       (bclk),
        .fs         (fs),
        .left_word  (adc_left),
        .right_word (right_sel),
        .slot_start (slot_q),
        .word_len   (word_length_field_q),
        .tri_lsb    (slot2_w[F_TRI]),
        .pad_oe_en  (slot2_w[F_PAD_OE]),
        .pull_en    (slot2_w[F_PULL_EN]),
        .pull_sel   (slot2_w[F_PULL_SEL]),
        .pad_out    (serial_data_out_pin_o),
        .pad_oe     (serial_data_out_pin_oe),
        .pull_up    (pad_pull_up),
        .pull_down  (pad_pull_down)
    );

    // checks
    sequence id_read_s;
        reg_rd_en && (reg_addr == A_BUSID);
    endsequence

    id_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_rd_en && reg_addr == A_REV) |=> (reg_rd_data == REV_ID))
        else $error("revision id read wrong");
    bus_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        id_read_s |=> (reg_rd_data[6:0] == BUS_ADDR) && (reg_rd_data[8:7] == 2'b00))
        else $error("bus address id read wrong");
    boost_gain_a: assert property (@(posedge clk) disable iff (!rstn)
        input_boost_gain_sel |=> (boost_stage_gain_db == BOOST_DB))
        else $error("boost gain not applied");
    spk_db_a: assert property (@(posedge clk) disable iff (!rstn)
        (speaker_gain_code == 6'h3F) ##1 $stable(speaker_gain_code)
        |-> (speaker_gain_db == 7'sd6))
        else $error("speaker gain top code not +6 dB");
    bias_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        !drv_w[F_HV_UPD] |=> !high_supply_bias_high)
        else $error("bias override without update bit");
    limiter_on_a: assert property (@(posedge clk) disable iff (!rstn)
        !regs_q[I_ALC2][F_LIM_OFF] |=> fast_limiter_active)
        else $error("fast limiter off while bit clear");
    word_len_a: assert property (@(posedge clk) disable iff (!rstn)
        slot2_w[F_BYTE] |=> (pcm_word_len == WL_BYTE))
        else $error("byte word length not forced");
    mono_vref_a: assert property (@(posedge clk) disable iff (!rstn)
        regs_q[I_MONOMIX][F_MONO_MUTE] |=> mono_drive_vref)
        else $error("muted mono output not at reference");
    slot_join_a: assert property (@(posedge clk) disable iff (!rstn)
        ($stable(slot1_w) && $stable(slot2_w))
        |-> (pcm_slot_start == {slot2_w[F_SLOT_MSB], slot1_w}))
        else $error("slot position assembled wrong");
    out_boost_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_OUT] && reg_wr_data[F_MONO_OUT_BOOST])
        |=> mono_out_boost)
        else $error("mono boost bit not stored");
    spk_boost_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_OUT] && !reg_wr_data[F_SPEAKER_OUT_BOOST])
        |=> !speaker_out_boost)
        else $error("speaker boost bit not cleared");
    spk_aux_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_SPKMIX] && reg_wr_data[F_MIX_AUX_S])
        |=> aux_to_speaker_mix)
        else $error("aux not connected to speaker mixer");
    spk_dac_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_SPKMIX] && !reg_wr_data[F_MIX_DAC])
        |=> !dac_to_speaker_mix)
        else $error("dac not disconnected from speaker mixer");
    mono_byp_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_MONOMIX] && reg_wr_data[F_MIX_BYP])
        |=> bypass_to_mono_mix)
        else $error("bypass not connected to mono mixer");
    mono_dac_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_MONOMIX] && !reg_wr_data[F_MIX_DAC])
        |=> !dac_to_mono_mix)
        else $error("dac not disconnected from mono mixer");
    low_power_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_LOWPWR] && reg_wr_data[F_LP_SPK])
        |=> low_power_speaker_driver)
        else $error("speaker driver low power not set");
    spk_mute_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_SPEAKER_GAIN_CODE] && reg_wr_data[F_SPK_MUTE])
        |=> speaker_mute)
        else $error("speaker mute not set");
    spk_db_low_a: assert property (@(posedge clk) disable iff (!rstn)
        (speaker_gain_code == 6'h00) ##1 $stable(speaker_gain_code)
        |-> (speaker_gain_db == -7'sd57))
        else $error("speaker gain bottom code not -57 dB");
    table_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_ALC1] && reg_wr_data[F_TABLE])
        |=> target_table_select)
        else $error("target table select not set");
    level_src_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_ALC1] && !reg_wr_data[F_LVL_SRC])
        |=> !level_threshold_source)
        else $error("level threshold source not peak");
    gate_src_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr_en && reg_addr == RW_ADDR[I_ALC1] && reg_wr_data[F_GATE_SRC])
        |=> gate_threshold_source)
        else $error("gate threshold source not peak-to-peak");
    xid_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
        (reg_rd_en && reg_addr == A_XID)
        |=> (reg_rd_data == EXTRA_ID))
        else $error("extra id read wrong");
    pull_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (!slot2_w[F_PAD_OE] && !slot2_w[F_PULL_EN])
        |=> (!pad_pull_up && !pad_pull_down))
        else $error("pad pulled while pull disabled");
endmodule

// File: ccr_pkg.sv
// constants for the codec output and pcm control register slice
// assumes a 9-bit register word and a 7-bit register address
package ccr_pkg;
    typedef logic [8:0] ccr_word_t;
    typedef logic [6:0] ccr_addr_t;

    localparam int NRW = 10;
    localparam int I_OUT = 0;
    localparam int I_SPKMIX = 1;
    localparam int I_SPEAKER_GAIN_CODE = 2;
    localparam int I_MONOMIX = 3;
    localparam int I_LOWPWR = 4;
    localparam int I_SLOT1 = 5;
    localparam int I_SLOT2 = 6;
    localparam int I_DRV = 7;
    localparam int I_ALC1 = 8;
    localparam int I_ALC2 = 9;

    localparam ccr_addr_t RW_ADDR [NRW] = '{7'h31, 7'h32, 7'h36, 7'h38, 7'h3A,
                                            7'h3B, 7'h3C, 7'h45, 7'h46, 7'h47};
    localparam ccr_word_t RW_RST [NRW] = '{9'h002, 9'h001, 9'h039, 9'h001, 9'h000,
                                           9'h000, 9'h000, 9'h001, 9'h000, 9'h000};
    localparam ccr_word_t RW_MASK [NRW] = '{9'h00F, 9'h023, 9'h0FF, 9'h047, 9'h1FF,
                                            9'h1FF, 9'h1FF, 9'h015, 9'h1C0, 9'h100};

    localparam ccr_addr_t A_REV = 7'h3E;
    localparam ccr_addr_t A_BUSID = 7'h3F;
    localparam ccr_addr_t A_XID = 7'h40;
    localparam ccr_addr_t A_RSVD = 7'h41;
    localparam ccr_word_t RSVD_VAL = 9'h124;

    // field positions
    localparam int F_ANALOG_OUT_RESISTANCE = 0;
    localparam int F_THERMAL_SHUTDOWN_EN = 1;
    localparam int F_SPEAKER_OUT_BOOST = 2;
    localparam int F_MONO_OUT_BOOST = 3;
    localparam int F_MIX_DAC = 0;
    localparam int F_MIX_BYP = 1;
    localparam int F_MIX_AUX_M = 2;
    localparam int F_MIX_AUX_S = 5;
    localparam int F_MONO_MUTE = 6;
    localparam int F_SPK_MUTE = 6;
    localparam int F_SPK_ZC = 7;
    localparam int F_LP_DAC = 5;
    localparam int F_LP_SPK = 6;
    localparam int F_LP_ADC = 7;
    localparam int F_LP_BST = 8;
    localparam int F_MICBM = 4;
    localparam int F_SLOT_MSB = 0;
    localparam int F_ALT = 1;
    localparam int F_DUP = 2;
    localparam int F_PULL_SEL = 3;
    localparam int F_PULL_EN = 4;
    localparam int F_PAD_OE = 5;
    localparam int F_BYTE = 6;
    localparam int F_TRI = 7;
    localparam int F_SLOT_EN = 8;
    localparam int F_HV_SEL = 0;
    localparam int F_HV_UPD = 2;
    localparam int F_OUT_MUTE = 4;
    localparam int F_TABLE = 6;
    localparam int F_LVL_SRC = 7;
    localparam int F_GATE_SRC = 8;
    localparam int F_LIM_OFF = 8;

    localparam logic [6:0] SPK_DB_OFS = 7'h39;
    localparam logic [4:0] BOOST_DB = 5'h14;
    localparam logic [5:0] WL_BYTE = 6'h08;
    localparam logic [5:0] WL_TABLE [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
endpackage

// File: ccr_pcm_tx.sv
// pcm transmit side of the audio port, drives the data-out pad
// assumes bclk and fs are synchronous inputs sampled by clk
`timescale 1ns/1ps
module ccr_pcm_tx (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // serial port
    input  wire logic        bclk,
    input  wire logic        fs,
    input  wire logic [31:0] left_word,
    input  wire logic [31:0] right_word,
    // settings
    input  wire logic [9:0]  slot_start,
    input  wire logic [5:0]  word_len,
    input  wire logic        tri_lsb,
    input  wire logic        pad_oe_en,
    input  wire logic        pull_en,
    input  wire logic        pull_sel,
    // pad
    output logic             pad_out,
    output logic             pad_oe,
    output logic             pull_up,
    output logic             pull_down
);
    typedef enum logic [1:0] {CTX_IDLE, CTX_DATA, CTX_REL} ccr_tx_t;
    ccr_tx_t     st_q, st_d;
    logic        bclk_q, fsl_q, bit_d;
    logic [10:0] cnt_q, pos;
    logic [6:0]  tot;
    logic        rise, fall, in_slot, lsb, drive_d;

    assign rise = bclk && !bclk_q;
    assign fall = !bclk && bclk_q;
    assign tot = {word_len, 1'b0};
    assign pos = cnt_q - {1'b0, slot_start};
    assign in_slot = (cnt_q >= {1'b0, slot_start}) && (pos < {4'h0, tot});
    assign lsb = (pos == {5'h00, word_len} - 11'h001) || (pos == {4'h0, tot} - 11'h001);
    assign bit_d = (pos < {5'h00, word_len})
                 ? left_word[5'(word_len - 6'h01 - pos[5:0])]
                 : right_word[5'(tot[5:0] - 6'h01 - pos[5:0])];

    always_comb begin
        st_d = st_q;
        if (fall) begin
            st_d = in_slot ? CTX_DATA : CTX_IDLE;
        end else if (rise && st_q == CTX_DATA && lsb && tri_lsb && !pad_oe_en) begin
            st_d = CTX_REL;
        end
        case (st_d)
            CTX_DATA: drive_d = 1'b1;
            CTX_REL:  drive_d = 1'b0;
            CTX_IDLE: drive_d = 1'b0;
            default:  drive_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bclk_q <= 1'b0;
            fsl_q <= 1'b0;
            cnt_q <= '1;
        end else begin
            bclk_q <= bclk;
            if (rise) begin
                fsl_q <= fs;
                cnt_q <= (fs && !fsl_q) ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 11'h001);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= CTX_IDLE;
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pull_up <= 1'b0;
            pull_down <= 1'b0;
        end else begin
            st_q <= st_d;
            if (fall) begin
                pad_out <= in_slot && bit_d;
            end
            pad_oe <= drive_d || pad_oe_en;
            pull_up <= !(drive_d || pad_oe_en) && pull_en && pull_sel;
            pull_down <= !(drive_d || pad_oe_en) && pull_en && !pull_sel;
        end
    end

    lsb_release_a: assert property (@(posedge clk) disable iff (!rstn)
        (rise && st_q == CTX_DATA && lsb && tri_lsb && !pad_oe_en) |=> !pad_oe)
        else $error("lsb not released after rising edge");
    pad_drive_a: assert property (@(posedge clk) disable iff (!rstn)
        pad_oe_en |=> pad_oe && !pull_up && !pull_down)
        else $error("pad not driven while output enable set");
endmodule

// File: tb_top.sv
// self-checking bench for the codec control register slice
// assumes ccr_pkg is compiled first; bench drives every port itself
`timescale 1ns/1ps
module tb_top;
    import ccr_pkg::*;
    logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, bsel = 0, bclk = 0, fs = 0;
    ccr_addr_t addr = '0;
    ccr_word_t wdat = '0, rdat;
    logic [5:0] gain_rb = 6'h01;
    logic [1:0] wl = 2'h0;
    logic [31:0] left = 32'h0000005C, right = 32'h00000093;
    logic so, soe, pu, pd, mob, sob, tsd, aor, a2s, b2s, d2s, szc, smt, a2m, b2m, d2m, vref;
    logic lpb, lpa, lps, lpd, micm, sme, alt, hva, hvh, tts, lts, gts, fla;
    logic [4:0] bdb;
    logic [5:0] sgc, pwl;
    logic signed [6:0] sdb;
    logic [3:0] trim;
    logic [9:0] slot;
    int mismatches = 0, comparisons = 0;
    ccr_word_t rv;
    ccr_addr_t ad [10] = '{7'h31, 7'h32, 7'h36, 7'h38, 7'h3A, 7'h3B, 7'h3C, 7'h45, 7'h46, 7'h47};
    ccr_word_t r0 [10] = '{9'h002, 9'h001, 9'h039, 9'h001, 9'h000, 9'h000, 9'h000, 9'h001,
                           9'h001, 9'h000};
    ccr_word_t r1 [10] = '{9'h00F, 9'h023, 9'h0FF, 9'h047, 9'h1FF, 9'h1FF, 9'h1FF, 9'h015,
                           9'h1C1, 9'h100};

    ccr_regs #(.REV_ID(9'h0A5), .BUS_ADDR(7'h2B), .EXTRA_ID(9'h0B3)) ccr_regs_i (
        .clk(clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wr_data(wdat), .reg_rd_data(rdat), .level_gain_readback(gain_rb),
        .word_length_field(wl), .input_boost_gain_sel(bsel), .bclk(bclk), .fs(fs),
        .adc_left(left), .adc_right(right), .serial_data_out_pin_o(so),
        .serial_data_out_pin_oe(soe), .pad_pull_up(pu), .pad_pull_down(pd),
        .boost_stage_gain_db(bdb), .mono_out_boost(mob), .speaker_out_boost(sob),
        .thermal_shutdown_en(tsd), .analog_out_resistance(aor), .aux_to_speaker_mix(a2s),
        .bypass_to_speaker_mix(b2s), .dac_to_speaker_mix(d2s), .speaker_gain_code(sgc),
        .speaker_gain_db(sdb), .speaker_gain_zero_cross(szc), .speaker_mute(smt),
        .aux_to_mono_mix(a2m), .bypass_to_mono_mix(b2m), .dac_to_mono_mix(d2m),
        .mono_drive_vref(vref), .low_power_input_boost(lpb), .low_power_converter_in(lpa),
        .low_power_speaker_driver(lps), .low_power_converter_out(lpd), .mic_bias_mode(micm),
        .trim_bits(trim), .pcm_slot_start(slot), .pcm_word_len(pwl), .pcm_slot_mode_en(sme),
        .pcm_alt_mode(alt), .high_supply_bias_active(hva), .high_supply_bias_high(hvh),
        .target_table_select(tts), .level_threshold_source(lts), .gate_threshold_source(gts),
        .fast_limiter_active(fla)
    );

    always #10 clk = ~clk;

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask

    task automatic wr(input ccr_addr_t a, input ccr_word_t d);
        @(posedge clk) begin wr_en <= 1; addr <= a; wdat <= d; end
        @(posedge clk) wr_en <= 0;
    endtask

    task automatic rd(input ccr_addr_t a, output ccr_word_t d);
        @(posedge clk) begin rd_en <= 1; addr <= a; end
        @(posedge clk) rd_en <= 0;
        @(negedge clk) d = rdat;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 10; i++) begin
            rd(ad[i], rv); chk(32'(rv), 32'(r0[i]), "reset");
            wr(ad[i], 9'h1FF); rd(ad[i], rv); chk(32'(rv), 32'(r1[i]), "ones");
        end
        settle();
        chk(32'({mob, sob, tsd, aor, a2s, b2s, d2s, szc, smt, a2m, b2m, d2m}), 32'hFFF, "o1");
        chk(32'({vref, sgc, sdb}), 32'h3F86, "spk1");
        chk(32'({lpb, lpa, lps, lpd, slot, pwl}), 32'hFFFC8, "pcm1");
        chk(32'({micm, trim, sme, alt}), 32'h7F, "trim1");
        chk(32'({hva, hvh, tts, lts, gts, fla}), 32'h3E, "alc1");
        for (int i = 0; i < 10; i++) wr(ad[i], 9'h000);
        settle();
        chk(32'({mob, sob, a2s, b2s, d2s, smt, a2m, b2m, d2m, vref}), 32'h0, "o0");
        chk(32'({sdb, lpb, lpa, lps, lpd, slot}), 32'h11C000, "spk0");
        chk(32'({micm, trim, sme, alt}), 32'h0, "trim0");
        chk(32'({hva, hvh, tts, lts, gts, fla}), 32'h01, "alc0");
        $display("test regs done");
    endtask

    task automatic t_misc();
        logic [5:0] wx [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
        for (int c = 0; c < 4; c++) begin
            @(posedge clk) wl <= 2'(c);
            settle(); chk(32'(pwl), 32'(wx[c]), "word_length_field");
        end
        wr(7'h45, 9'h001); settle(); chk(32'({hva, hvh}), 32'h0, "hv no upd");
        wr(7'h45, 9'h004); settle(); chk(32'({hva, hvh}), 32'h2, "hv low");
        wr(7'h45, 9'h015); settle(); chk(32'({hva, hvh, vref}), 32'h7, "hv high");
        wr(7'h38, 9'h040); wr(7'h45, 9'h000); settle(); chk(32'(vref), 32'h1, "vref");
        @(posedge clk) bsel <= 1;
        settle(); chk(32'(bdb), 32'h14, "boost");
        @(posedge clk) bsel <= 0;
        settle(); chk(32'(bdb), 32'h00, "noboost");
        for (int a = 7'h3E; a < 7'h42; a++) wr(7'(a), 9'h1FF);
        rd(7'h3E, rv); chk(32'(rv), 32'h0A5, "rev");
        rd(7'h3F, rv); chk(32'(rv), 32'h02B, "busid");
        rd(7'h40, rv); chk(32'(rv), 32'h0B3, "xid");
        rd(7'h41, rv); chk(32'(rv), 32'h124, "rsvd");
        wr(7'h7F, 9'h1FF); rd(7'h7F, rv); chk(32'(rv), 32'h0, "unmapped");
        @(posedge clk) gain_rb <= 6'h15;
        rd(7'h46, rv); chk(32'(rv), 32'h015, "readback");
        $display("test misc done");
    endtask

    task automatic t_frame(input ccr_word_t cfg);
        logic tri_b, dup, oe, pe, ps, ins;
        logic [7:0] rw;
        int p;
        tri_b = cfg[7]; oe = cfg[5]; pe = cfg[4]; ps = cfg[3]; dup = cfg[2];
        rw = dup ? left[7:0] : right[7:0];
        wr(7'h3B, 9'h001); wr(7'h3C, cfg);
        @(posedge clk) fs <= 1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 20; i++) begin
            p = i - 1;
            bclk <= 1;
            repeat (2) @(posedge clk);
            fs <= 0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            ins = (p - 1 >= 0) && (p - 1 < 16);
            chk(32'(soe), 32'(oe | (ins & ~(tri_b & (p - 1 == 7 || p - 1 == 15)))), "hi oe");
            @(posedge clk) bclk <= 0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            ins = (p >= 0) && (p < 16);
            if (ins) chk(32'({soe, so}), 32'({1'b1, p < 8 ? left[7 - p] : rw[15 - p]}), "bit");
            else if (oe) chk(32'({soe, so}), 32'h2, "idle drive");
            else chk(32'({soe, pu, pd}), 32'({1'b0, pe & ps, pe & ~ps}), "pull");
            @(posedge clk);
        end
        $display("test frame %h done", cfg);
    endtask

    task automatic stop_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1;
        t_regs();
        t_misc();
        t_frame(9'h1D8);
        t_frame(9'h154);
        t_frame(9'h1E0);
        stop_test();
    end
endmodule
